/* core/uart_fifo_ctrl_shadow_regs.sv */
// fifo control word with its four single-field shadow registers and dma request logic
`timescale 1ns/1ns
`include "uart_fifo_ctrl_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// - bit 0 of dma select shadow writes only the dma mode bit
// - dma mode 0 or 1 chooses how both dma request lines signal
// - bit 0 of fifo enable shadow enables both fifos, nothing else changes
// - clearing fifo enable after enabled resets both fifo controllers
// - bits 1:0 of receive trigger shadow write only that field
// - receive data interrupt at one, quarter, half, or two short of full
// - in dma mode 1 receive request asserts at the receive trigger level
// - bits 1:0 of transmit threshold shadow write only that field
// - threshold mode: transmit empty interrupt at empty, two, or half full
module uart_fifo_ctrl_shadow_regs #(
	parameter int DEPTH = `UFC_FIFO_DEPTH,
	parameter int LW = $clog2(DEPTH) + 1
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [31:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [15:0] regRdata,
	input wire logic [LW-1:0] txLevel,
	input wire logic [LW-1:0] rxLevel,
	input wire logic thresholdMode,
	output logic fifoEnable,
	output logic dmaMode,
	output logic rxDataAvailIrq,
	output logic txHoldingEmptyIrq,
	output logic dmaTxReqN,
	output logic dmaRxReqN,
	output logic txFifoCtrlReset,
	output logic rxFifoCtrlReset,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	// address decode, shared by the write path and the read path
	function automatic uart_fifo_ctrl_pkg::reg_sel_t decode(input logic [31:0] a);
		uart_fifo_ctrl_pkg::reg_sel_t s;
		s = uart_fifo_ctrl_pkg::SEL_NONE;
		unique case (a)
			`UFC_FCW_ADDR: s = uart_fifo_ctrl_pkg::SEL_FCW;
			`UFC_IRQ_STATUS_ADDR: s = uart_fifo_ctrl_pkg::SEL_STATUS;
			`UFC_IRQ_MASK_ADDR: s = uart_fifo_ctrl_pkg::SEL_MASK;
			`UFC_DMA_SEL_ADDR: s = uart_fifo_ctrl_pkg::SEL_DMA;
			`UFC_FIFO_EN_ADDR: s = uart_fifo_ctrl_pkg::SEL_FEN;
			`UFC_RX_TRIG_ADDR: s = uart_fifo_ctrl_pkg::SEL_RXT;
			`UFC_TX_THR_ADDR: s = uart_fifo_ctrl_pkg::SEL_TXT;
			default: s = uart_fifo_ctrl_pkg::SEL_NONE;
		endcase
		return s;
	endfunction : decode

	// receive trigger level in entries
	function automatic logic [LW-1:0] rxTrigLevel(input logic [1:0] sel);
		logic [LW-1:0] v;
		v = LW'(1);
		unique case (sel)
			2'h0: v = LW'(1);
			2'h1: v = LW'(DEPTH / 4);
			2'h2: v = LW'(DEPTH / 2);
			2'h3: v = LW'(DEPTH - `UFC_RX_TOP_GAP);
		endcase
		return v;
	endfunction : rxTrigLevel

	// transmit empty threshold in entries; 11 is taken as half full like 10
	function automatic logic [LW-1:0] txThrLevel(input logic [1:0] sel);
		logic [LW-1:0] v;
		v = LW'(0);
		unique case (sel)
			2'h0: v = LW'(0);
			2'h1: v = LW'(`UFC_TX_LOW_MARK);
			2'h2: v = LW'(DEPTH / 2);
			2'h3: v = LW'(DEPTH / 2);
		endcase
		return v;
	endfunction : txThrLevel

	////////////////////////////////////////////////////////////////////////////////
	// state

	uart_fifo_ctrl_pkg::fcw_t fcw_r;
	uart_fifo_ctrl_pkg::fcw_t fcw_nxt;
	logic txRst_r;
	logic txRst_nxt;
	logic rxRst_r;
	logic rxRst_nxt;
	logic [`UFC_IRQ_W-1:0] status_r;
	logic [`UFC_IRQ_W-1:0] status_nxt;
	logic [`UFC_IRQ_W-1:0] mask_r;
	logic [`UFC_IRQ_W-1:0] mask_nxt;
	logic [15:0] rdata_r;
	logic [15:0] rdata_nxt;
	logic rxIrq_r;
	logic rxIrq_nxt;
	logic txIrq_r;
	logic txIrq_nxt;
	uart_fifo_ctrl_pkg::dma_req_t rxReq_r;
	uart_fifo_ctrl_pkg::dma_req_t rxReq_nxt;
	uart_fifo_ctrl_pkg::dma_req_t txReq_r;
	uart_fifo_ctrl_pkg::dma_req_t txReq_nxt;

	uart_fifo_ctrl_pkg::reg_sel_t sel;
	logic rxHit;
	logic txHit;
	logic disableEdge;
	logic [`UFC_IRQ_W-1:0] events;

	assign sel = decode(regAddr);

	////////////////////////////////////////////////////////////////////////////////
	// control word and its shadows

	// one stored word: each shadow path writes only its own field, so no read-modify-write
	always_comb begin
		fcw_nxt = fcw_r;
		if (regWrite) begin
			unique case (sel)
				uart_fifo_ctrl_pkg::SEL_FCW: begin
					fcw_nxt.fifoEn = regWdata[`UFC_FCW_EN_BIT];
					fcw_nxt.dmaMode = regWdata[`UFC_FCW_DMA_BIT];
					fcw_nxt.txTrig = regWdata[`UFC_FCW_TXTRIG_HI:`UFC_FCW_TXTRIG_LO];
					fcw_nxt.rxTrig = regWdata[`UFC_FCW_RXTRIG_HI:`UFC_FCW_RXTRIG_LO];
				end
				uart_fifo_ctrl_pkg::SEL_DMA: fcw_nxt.dmaMode = regWdata[0];
				uart_fifo_ctrl_pkg::SEL_FEN: fcw_nxt.fifoEn = regWdata[0];
				uart_fifo_ctrl_pkg::SEL_RXT: fcw_nxt.rxTrig = regWdata[1:0];
				uart_fifo_ctrl_pkg::SEL_TXT: fcw_nxt.txTrig = regWdata[1:0];
				default: fcw_nxt = fcw_r;
			endcase
		end
	end

	// fifo controller resets: a falling enable hits both, control word bits hit one each
	always_comb begin
		disableEdge = fcw_r.fifoEn & ~fcw_nxt.fifoEn;
		txRst_nxt = disableEdge;
		rxRst_nxt = disableEdge;
		if (regWrite && sel == uart_fifo_ctrl_pkg::SEL_FCW) begin
			txRst_nxt = disableEdge | regWdata[`UFC_FCW_TXRST_BIT];
			rxRst_nxt = disableEdge | regWdata[`UFC_FCW_RXRST_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			fcw_r <= `UFC_FCW_RESET;
			txRst_r <= 1'h0;
			rxRst_r <= 1'h0;
		end else begin
			fcw_r <= fcw_nxt;
			txRst_r <= txRst_nxt;
			rxRst_r <= rxRst_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupt conditions

	// without fifos the receive side needs one character and transmit needs empty
	always_comb begin
		if (fcw_r.fifoEn) begin
			rxHit = rxLevel >= rxTrigLevel(fcw_r.rxTrig);
		end else begin
			rxHit = rxLevel != LW'(0);
		end
		if (fcw_r.fifoEn && thresholdMode) begin
			txHit = txLevel <= txThrLevel(fcw_r.txTrig);
		end else begin
			txHit = txLevel == LW'(0);
		end
		rxIrq_nxt = rxHit;
		txIrq_nxt = txHit;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rxIrq_r <= 1'h0;
			txIrq_r <= 1'h0;
		end else begin
			rxIrq_r <= rxIrq_nxt;
			txIrq_r <= txIrq_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// dma request channels

	// mode 0 follows single characters; mode 1 holds the request with hysteresis
	always_comb begin
		rxReq_nxt = rxReq_r;
		txReq_nxt = txReq_r;
		if (!fcw_r.dmaMode) begin
			// mode 0
			rxReq_nxt = (rxLevel != LW'(0)) ? uart_fifo_ctrl_pkg::REQ_ACTIVE
				: uart_fifo_ctrl_pkg::REQ_IDLE;
			txReq_nxt = txHit ? uart_fifo_ctrl_pkg::REQ_ACTIVE : uart_fifo_ctrl_pkg::REQ_IDLE;
		end else begin
			// mode 1: receive asserts at the trigger level, drops once drained
			unique case (rxReq_r)
				uart_fifo_ctrl_pkg::REQ_IDLE: begin
					if (rxHit) begin
						rxReq_nxt = uart_fifo_ctrl_pkg::REQ_ACTIVE;
					end
				end
				uart_fifo_ctrl_pkg::REQ_ACTIVE: begin
					if (rxLevel == LW'(0)) begin
						rxReq_nxt = uart_fifo_ctrl_pkg::REQ_IDLE;
					end
				end
			endcase
			// transmit asserts at the empty threshold, drops once the fifo is full or the fifos are disabled
			unique case (txReq_r)
				uart_fifo_ctrl_pkg::REQ_IDLE: begin
					if (txHit) begin
						txReq_nxt = uart_fifo_ctrl_pkg::REQ_ACTIVE;
					end
				end
				uart_fifo_ctrl_pkg::REQ_ACTIVE: begin
					if (txLevel >= LW'(DEPTH) || !fcw_r.fifoEn) begin
						txReq_nxt = uart_fifo_ctrl_pkg::REQ_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rxReq_r <= uart_fifo_ctrl_pkg::REQ_IDLE;
			txReq_r <= uart_fifo_ctrl_pkg::REQ_IDLE;
		end else begin
			rxReq_r <= rxReq_nxt;
			txReq_r <= txReq_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sticky interrupt status and mask

	// rising edges of the conditions; a set in the clear cycle survives
	always_comb begin
		events = '0;
		events[`UFC_IRQ_RX_BIT] = rxHit & ~rxIrq_r;
		events[`UFC_IRQ_TX_BIT] = txHit & ~txIrq_r;
		events[`UFC_IRQ_DIS_BIT] = disableEdge;
		status_nxt = status_r;
		mask_nxt = mask_r;
		if (regWrite && sel == uart_fifo_ctrl_pkg::SEL_STATUS) begin
			status_nxt = status_r & ~regWdata[`UFC_IRQ_W-1:0];
		end
		if (regWrite && sel == uart_fifo_ctrl_pkg::SEL_MASK) begin
			mask_nxt = regWdata[`UFC_IRQ_W-1:0];
		end
		status_nxt = status_nxt | events;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			status_r <= `UFC_IRQ_RESET;
			mask_r <= `UFC_IRQ_RESET;
		end else begin
			status_r <= status_nxt;
			mask_r <= mask_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read path

	// the control word itself is write-only and reads zero, as do unmapped addresses
	always_comb begin
		rdata_nxt = 16'h0000;
		if (regRead) begin
			unique case (sel)
				uart_fifo_ctrl_pkg::SEL_STATUS: rdata_nxt[`UFC_IRQ_W-1:0] = status_r;
				uart_fifo_ctrl_pkg::SEL_MASK: rdata_nxt[`UFC_IRQ_W-1:0] = mask_r;
				uart_fifo_ctrl_pkg::SEL_DMA: rdata_nxt[0] = fcw_r.dmaMode;
				uart_fifo_ctrl_pkg::SEL_FEN: rdata_nxt[0] = fcw_r.fifoEn;
				uart_fifo_ctrl_pkg::SEL_RXT: rdata_nxt[1:0] = fcw_r.rxTrig;
				uart_fifo_ctrl_pkg::SEL_TXT: rdata_nxt[1:0] = fcw_r.txTrig;
				default: rdata_nxt = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rdata_r <= 16'h0000;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign regRdata = rdata_r;
	assign fifoEnable = fcw_r.fifoEn;
	assign dmaMode = fcw_r.dmaMode;
	assign rxDataAvailIrq = rxIrq_r;
	assign txHoldingEmptyIrq = txIrq_r;
	assign dmaRxReqN = rxReq_r != uart_fifo_ctrl_pkg::REQ_ACTIVE; // active low
	assign dmaTxReqN = txReq_r != uart_fifo_ctrl_pkg::REQ_ACTIVE; // active low
	assign txFifoCtrlReset = txRst_r;
	assign rxFifoCtrlReset = rxRst_r;
	assign irq = |(status_r & mask_r);

endmodule : uart_fifo_ctrl_shadow_regs

/* core/uart_fifo_ctrl_defines.svh */
// offsets, field positions, reset values and counts for the fifo control shadow block
`ifndef UART_FIFO_CTRL_DEFINES_SVH
`define UART_FIFO_CTRL_DEFINES_SVH

// register byte addresses
`define UFC_FCW_ADDR 32'h5000_1170
`define UFC_IRQ_STATUS_ADDR 32'h5000_1174
`define UFC_IRQ_MASK_ADDR 32'h5000_1178
`define UFC_DMA_SEL_ADDR 32'h5000_1194
`define UFC_FIFO_EN_ADDR 32'h5000_1198
`define UFC_RX_TRIG_ADDR 32'h5000_119c
`define UFC_TX_THR_ADDR 32'h5000_11a0

// fields of the fifo control word
`define UFC_FCW_EN_BIT 0
`define UFC_FCW_RXRST_BIT 1
`define UFC_FCW_TXRST_BIT 2
`define UFC_FCW_DMA_BIT 3
`define UFC_FCW_TXTRIG_LO 4
`define UFC_FCW_TXTRIG_HI 5
`define UFC_FCW_RXTRIG_LO 6
`define UFC_FCW_RXTRIG_HI 7

// interrupt status bits
`define UFC_IRQ_RX_BIT 0
`define UFC_IRQ_TX_BIT 1
`define UFC_IRQ_DIS_BIT 2
`define UFC_IRQ_W 3

// reset values
`define UFC_FCW_RESET 6'h00
`define UFC_IRQ_RESET 3'h0

// default fifo depth in entries
`define UFC_FIFO_DEPTH 16
// entries short of full for the highest receive trigger
`define UFC_RX_TOP_GAP 2
// characters left for the low transmit threshold
`define UFC_TX_LOW_MARK 2

`endif

/* core/uart_fifo_ctrl_pkg.sv */
// types shared by the fifo control shadow block
package uart_fifo_ctrl_pkg;

	// stored fifo control word, one copy behind all shadows
	typedef struct packed {
		logic [1:0] rxTrig;
		logic [1:0] txTrig;
		logic dmaMode;
		logic fifoEn;
	} fcw_t;

	// dma request channel state
	typedef enum logic {
		REQ_IDLE,
		REQ_ACTIVE
	} dma_req_t;

	// register selected by an address
	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_FCW,
		SEL_STATUS,
		SEL_MASK,
		SEL_DMA,
		SEL_FEN,
		SEL_RXT,
		SEL_TXT
	} reg_sel_t;

endpackage : uart_fifo_ctrl_pkg

/* testbench/ufc_properties.sv */
// port assertions for the fifo control shadow block
`timescale 1ns/1ns
`include "uart_fifo_ctrl_defines.svh"
module ufc_properties #(
	parameter int DEPTH = 16,
	parameter int LW = 5
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [31:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [15:0] regRdata,
	input wire logic [LW-1:0] txLevel,
	input wire logic [LW-1:0] rxLevel,
	input wire logic thresholdMode,
	input wire logic fifoEnable,
	input wire logic dmaMode,
	input wire logic rxDataAvailIrq,
	input wire logic txHoldingEmptyIrq,
	input wire logic dmaTxReqN,
	input wire logic dmaRxReqN,
	input wire logic txFifoCtrlReset,
	input wire logic rxFifoCtrlReset,
	input wire logic irq
);
	logic [3:0] trig_r;
	logic [3:0] trig_nxt;
	logic rxCond;
	logic txCond;
	int rxMark;
	int txMark;
	// mirror of both trigger fields, fed by shadows and control word alike
	always_comb begin
		trig_nxt = trig_r;
		if (regWrite && regAddr == `UFC_RX_TRIG_ADDR) trig_nxt[3:2] = regWdata[1:0];
		if (regWrite && regAddr == `UFC_TX_THR_ADDR) trig_nxt[1:0] = regWdata[1:0];
		if (regWrite && regAddr == `UFC_FCW_ADDR) trig_nxt = regWdata[7:4];
		rxMark = trig_r[3] ? (trig_r[2] ? DEPTH - 2 : DEPTH / 2) : (trig_r[2] ? DEPTH / 4 : 1);
		txMark = trig_r[1] ? DEPTH / 2 : (trig_r[0] ? 2 : 0);
		rxCond = fifoEnable ? int'(rxLevel) >= rxMark : rxLevel != '0;
		txCond = (fifoEnable && thresholdMode) ? int'(txLevel) <= txMark : txLevel == '0;
	end
	always_ff @(posedge clock) begin
		trig_r <= rst ? 4'h0 : trig_nxt;
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_disWrite;
		fifoEnable && regWrite && regAddr == `UFC_FIFO_EN_ADDR && !regWdata[0];
	endsequence
	sequence s_bothPulse;
		txFifoCtrlReset && rxFifoCtrlReset ##1 !txFifoCtrlReset && !rxFifoCtrlReset;
	endsequence
	property p_rdIdle; !$past(regRead) |-> regRdata == 16'h0; endproperty
	a_rdIdle: assert property (p_rdIdle) else $error("read data outside read slot");
	property p_dmaWr;
		regWrite && regAddr == `UFC_DMA_SEL_ADDR |=> dmaMode == $past(regWdata[0]) && $stable(fifoEnable);
	endproperty
	a_dmaWr: assert property (p_dmaWr) else $error("dma select write wrong");
	property p_fenWr;
		regWrite && regAddr == `UFC_FIFO_EN_ADDR |=> fifoEnable == $past(regWdata[0]) && $stable(dmaMode);
	endproperty
	a_fenWr: assert property (p_fenWr) else $error("fifo enable write wrong");
	property p_disRst; s_disWrite |=> s_bothPulse; endproperty
	a_disRst: assert property (p_disRst) else $error("no fifo reset pulse on disable");
	// the reset-release edge is left out: the flops were still held there
	property p_rxIrq; !rst |=> rxDataAvailIrq == $past(rxCond); endproperty
	a_rxIrq: assert property (p_rxIrq) else $error("receive irq level wrong");
	property p_txIrq; !rst |=> txHoldingEmptyIrq == $past(txCond); endproperty
	a_txIrq: assert property (p_txIrq) else $error("transmit irq level wrong");
	property p_rxReq0; !dmaMode && rxLevel != '0 |=> !dmaRxReqN; endproperty
	a_rxReq0: assert property (p_rxReq0) else $error("mode 0 receive request missing");
	property p_txReq0; !rst && !dmaMode |=> dmaTxReqN == !$past(txCond); endproperty
	a_txReq0: assert property (p_txReq0) else $error("mode 0 transmit request wrong");
	property p_rxReq1; dmaMode && rxCond |=> !dmaRxReqN; endproperty
	a_rxReq1: assert property (p_rxReq1) else $error("mode 1 receive request missing");
	property p_rxReqOff; rxLevel == '0 |=> dmaRxReqN; endproperty
	a_rxReqOff: assert property (p_rxReqOff) else $error("receive request while empty");
endmodule : ufc_properties

/* testbench/dma_model.sv */
// dma controller model: drains the receive fifo and fills the transmit fifo
`timescale 1ns/1ns
module dma_model #(
	parameter int DEPTH = 16,
	parameter int LW = 5
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic dmaRxReqN,
	input wire logic dmaTxReqN,
	input wire logic serve,
	input wire logic load,
	input wire logic [LW-1:0] rxSet,
	input wire logic [LW-1:0] txSet,
	output logic [LW-1:0] rxLevel,
	output logic [LW-1:0] txLevel
);
	logic [LW-1:0] rx_r;
	logic [LW-1:0] tx_r;
	logic [LW-1:0] rx_nxt;
	logic [LW-1:0] tx_nxt;
	// one entry per cycle while a request is low; serve low stalls the controller
	always_comb begin
		rx_nxt = rx_r;
		tx_nxt = tx_r;
		if (load) begin
			rx_nxt = rxSet;
			tx_nxt = txSet;
		end else if (serve) begin
			if (!dmaRxReqN && rx_r != '0) rx_nxt = rx_r - 1'b1;
			if (!dmaTxReqN && int'(tx_r) < DEPTH) tx_nxt = tx_r + 1'b1;
		end
	end
	always_ff @(posedge clock) begin
		rx_r <= rst ? '0 : rx_nxt;
		tx_r <= rst ? '0 : tx_nxt;
	end
	assign rxLevel = rx_r;
	assign txLevel = tx_r;
endmodule : dma_model

/* testbench/uart_fifo_ctrl_shadow_regs_tb.sv */
// self-checking bench for the fifo control shadow block
`timescale 1ns/1ns
`include "uart_fifo_ctrl_defines.svh"
module uart_fifo_ctrl_shadow_regs_tb;
	localparam int DEPTH = 16;
	localparam int LW = 5;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [31:0] regAddr = 32'h0;
	logic [15:0] regWdata = 16'h0;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic thresholdMode = 1'b0;
	logic serve = 1'b0;
	logic load = 1'b0;
	logic [LW-1:0] rxSet = 5'h00;
	logic [LW-1:0] txSet = 5'h00;
	logic [15:0] regRdata;
	logic [LW-1:0] txLevel;
	logic [LW-1:0] rxLevel;
	logic fifoEnable, dmaMode, rxDataAvailIrq, txHoldingEmptyIrq, irq;
	logic dmaTxReqN, dmaRxReqN, txFifoCtrlReset, rxFifoCtrlReset;
	int errTotal = 0;
	int cmpCount = 0;
	logic [31:0] shAddr [4] = '{`UFC_DMA_SEL_ADDR, `UFC_FIFO_EN_ADDR, `UFC_RX_TRIG_ADDR,
		`UFC_TX_THR_ADDR};
	logic [15:0] shFull [4] = '{16'h1, 16'h1, 16'h3, 16'h3};
	int rxMark [4] = '{1, DEPTH / 4, DEPTH / 2, DEPTH - 2};
	int txMark [4] = '{0, 2, DEPTH / 2, DEPTH / 2};
	uart_fifo_ctrl_shadow_regs #(.DEPTH(DEPTH)) u_uart_fifo_ctrl_shadow_regs (.clock(clock),
		.rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
		.regRead(regRead), .regRdata(regRdata), .txLevel(txLevel), .rxLevel(rxLevel),
		.thresholdMode(thresholdMode), .fifoEnable(fifoEnable), .dmaMode(dmaMode),
		.rxDataAvailIrq(rxDataAvailIrq), .txHoldingEmptyIrq(txHoldingEmptyIrq),
		.dmaTxReqN(dmaTxReqN), .dmaRxReqN(dmaRxReqN), .txFifoCtrlReset(txFifoCtrlReset),
		.rxFifoCtrlReset(rxFifoCtrlReset), .irq(irq));
	dma_model #(.DEPTH(DEPTH), .LW(LW)) u_dma_model (.clock(clock), .rst(rst),
		.dmaRxReqN(dmaRxReqN), .dmaTxReqN(dmaTxReqN), .serve(serve), .load(load),
		.rxSet(rxSet), .txSet(txSet), .rxLevel(rxLevel), .txLevel(txLevel));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #50 clock = ~clock;
	end
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			errTotal++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		@(posedge clock);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
		#1;
	endtask : wr
	// read data stand only in the cycle after the strobe, so sample right there
	task automatic rdChk(input logic [31:0] a, input logic [15:0] exp);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1;
		chk("regRdata", regRdata, exp);
	endtask : rdChk
	// new fifo levels, then two edges for the registered conditions to follow
	task automatic setLv(input logic [LW-1:0] r, input logic [LW-1:0] t);
		@(posedge clock);
		rxSet <= r;
		txSet <= t;
		load <= 1'b1;
		@(posedge clock);
		load <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
	endtask : setLv
	task automatic endOfTest;
		if (errTotal == 0 && cmpCount > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : endOfTest
	initial begin
		repeat (20000) @(posedge clock);
		errTotal++;
		endOfTest();
	end
	initial begin
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++) rdChk(shAddr[i], 16'h0);
		// each shadow write must leave the other fields alone
		for (int i = 0; i < 4; i++) begin
			wr(shAddr[i], 16'hffff);
			for (int j = 0; j < 4; j++) begin
				rdChk(shAddr[j], (j <= i) ? shFull[j] : 16'h0);
			end
		end
		wr(`UFC_FCW_ADDR, 16'h0019);
		rdChk(`UFC_DMA_SEL_ADDR, 16'h1);
		rdChk(`UFC_FIFO_EN_ADDR, 16'h1);
		rdChk(`UFC_RX_TRIG_ADDR, 16'h0);
		rdChk(`UFC_TX_THR_ADDR, 16'h1);
		rdChk(`UFC_FCW_ADDR, 16'h0);
		rdChk(32'h5000_11a4, 16'h0);
		wr(`UFC_IRQ_MASK_ADDR, 16'h0);
		wr(`UFC_IRQ_STATUS_ADDR, 16'h7);
		for (int k = 0; k < 4; k++) begin
			wr(`UFC_RX_TRIG_ADDR, 16'(k));
			setLv(LW'(rxMark[k] - 1), 5'h00);
			chk("rxDataAvailIrq", 16'(rxDataAvailIrq), 16'h0);
			setLv(LW'(rxMark[k]), 5'h00);
			chk("rxDataAvailIrq", 16'(rxDataAvailIrq), 16'h1);
			chk("dmaRxReqN", 16'(dmaRxReqN), 16'h0);
		end
		// sticky status, masked out first, then let through and cleared
		// transmit condition stayed high all along, so only the receive event is latched
		rdChk(`UFC_IRQ_STATUS_ADDR, 16'h1);
		chk("irq", 16'(irq), 16'h0);
		wr(`UFC_IRQ_MASK_ADDR, 16'h1);
		chk("irq", 16'(irq), 16'h1);
		wr(`UFC_IRQ_STATUS_ADDR, 16'h1);
		chk("irq", 16'(irq), 16'h0);
		@(posedge clock);
		thresholdMode <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			wr(`UFC_TX_THR_ADDR, 16'(k));
			setLv(5'h00, LW'(txMark[k] + 1));
			chk("txHoldingEmptyIrq", 16'(txHoldingEmptyIrq), 16'h0);
			setLv(5'h00, LW'(txMark[k]));
			chk("txHoldingEmptyIrq", 16'(txHoldingEmptyIrq), 16'h1);
		end
		// the transmit condition rose again inside the loop
		rdChk(`UFC_IRQ_STATUS_ADDR, 16'h2);
		// a single entry, three below the trigger of four: only mode 0 asks for service
		wr(`UFC_RX_TRIG_ADDR, 16'h1);
		setLv(5'h01, 5'h00);
		chk("dmaRxReqN", 16'(dmaRxReqN), 16'h1);
		wr(`UFC_DMA_SEL_ADDR, 16'h0);
		repeat (2) @(posedge clock);
		#1;
		chk("dmaRxReqN", 16'(dmaRxReqN), 16'h0);
		wr(`UFC_DMA_SEL_ADDR, 16'h1);
		setLv(5'h04, 5'h00);
		@(posedge clock);
		serve <= 1'b1;
		for (int n = 0; n < 60 && !(rxLevel === 5'h00 && txLevel === 5'h10); n++) begin
			@(posedge clock);
		end
		repeat (2) @(posedge clock);
		#1;
		chk("rxLevel", 16'(rxLevel), 16'h0);
		chk("txLevel", 16'(txLevel), 16'h10);
		chk("dmaRxReqN", 16'(dmaRxReqN), 16'h1);
		chk("dmaTxReqN", 16'(dmaTxReqN), 16'h1);
		wr(`UFC_IRQ_STATUS_ADDR, 16'h7);
		wr(`UFC_IRQ_MASK_ADDR, 16'h4);
		wr(`UFC_FIFO_EN_ADDR, 16'h0);
		chk("txFifoCtrlReset", 16'(txFifoCtrlReset), 16'h1);
		chk("rxFifoCtrlReset", 16'(rxFifoCtrlReset), 16'h1);
		chk("irq", 16'(irq), 16'h1);
		// control word reset bit for the transmit side alone
		wr(`UFC_FCW_ADDR, 16'h0004);
		chk("txFifoCtrlReset", 16'(txFifoCtrlReset), 16'h1);
		chk("rxFifoCtrlReset", 16'(rxFifoCtrlReset), 16'h0);
		endOfTest();
	end
endmodule : uart_fifo_ctrl_shadow_regs_tb
bind uart_fifo_ctrl_shadow_regs ufc_properties #(.DEPTH(DEPTH), .LW(LW)) u_ufc_properties (
	.clock(clock), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
	.regRead(regRead), .regRdata(regRdata), .txLevel(txLevel), .rxLevel(rxLevel),
	.thresholdMode(thresholdMode), .fifoEnable(fifoEnable), .dmaMode(dmaMode),
	.rxDataAvailIrq(rxDataAvailIrq), .txHoldingEmptyIrq(txHoldingEmptyIrq),
	.dmaTxReqN(dmaTxReqN), .dmaRxReqN(dmaRxReqN), .txFifoCtrlReset(txFifoCtrlReset),
	.rxFifoCtrlReset(rxFifoCtrlReset), .irq(irq));
